// file: core/cfg_reg_bank.sv
// module: processor configuration register bank with watch and interrupt-controller outputs
module cfg_reg_bank
	import cfg_reg_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	// register access from the instruction pipeline
	input  wire cfg_req_s          req_i,
	output cfg_rsp_s               rsp_o,
	// counter write mode: 1 full width, 0 low half written and high half cleared
	input  wire logic              ext_wr_mode_i,
	// fault capture from the machine-check logic
	input  wire logic              mc_log_i,
	input  wire logic [DATA_W-1:0] mc_addr_i,
	input  wire logic [DATA_W-1:0] mc_type_i,
	// platform and boot selection from pins
	input  wire logic [PLAT_W-1:0] platform_id_i,
	input  wire logic              boot_sel_i,
	// to the address-watch unit and interrupt controller
	output logic      [LINE_W-1:0] watch_line_size_o,
	output logic      [DATA_W-1:0] cycle_count_o,
	output logic                   irq_ctrl_enable_o,
	output logic      [BASE_W-1:0] irq_ctrl_base_o,
	output logic                   bootstrap_processor_flag_o
);
	// pin synchronisers
	logic [PLAT_W-1:0] plat_s1_q;
	logic [PLAT_W-1:0] plat_s1_d;
	logic [PLAT_W-1:0] plat_s2_q;
	logic [PLAT_W-1:0] plat_s2_d;
	logic              boot_s1_q;
	logic              boot_s1_d;
	logic              boot_s2_q;
	logic              boot_s2_d;

	always_comb
	begin
		plat_s1_d = platform_id_i;
		plat_s2_d = plat_s1_q;
		boot_s1_d = boot_sel_i;
		boot_s2_d = boot_s1_q;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			plat_s1_q <= '0;
			plat_s2_q <= '0;
			boot_s1_q <= 1'b0;
			boot_s2_q <= 1'b0;
		end
		else
		begin
			plat_s1_q <= plat_s1_d;
			plat_s2_q <= plat_s2_d;
			boot_s1_q <= boot_s1_d;
			boot_s2_q <= boot_s2_d;
		end
	end

	// register state
	logic [DATA_W-1:0] mc_addr_q;
	logic [DATA_W-1:0] mc_addr_d;
	logic [DATA_W-1:0] mc_type_q;
	logic [DATA_W-1:0] mc_type_d;
	logic [LINE_W-1:0] line_q;
	logic [LINE_W-1:0] line_d;
	logic              gen_q;
	logic              gen_d;
	logic [BASE_W-1:0] base_q;
	logic [BASE_W-1:0] base_d;
	logic              boot_flag_q;
	logic              boot_flag_d;
	logic [PLAT_W-1:0] plat_q;
	logic [PLAT_W-1:0] plat_d;
	cfg_rsp_s          rsp_q;
	cfg_rsp_s          rsp_d;
	logic [DATA_W-1:0] cnt;

	function automatic logic hit(input logic [ADDR_W-1:0] idx, input logic [31:0] reg_idx);
		hit = (idx == reg_idx);
	endfunction : hit

	// decoded write strobes
	logic              wr_cnt;
	logic              wr_line;
	logic              wr_base;
	logic              wr_known;

	assign wr_cnt   = req_i.wr && hit(req_i.idx, IDX_CYCLE_CNT);
	assign wr_line  = req_i.wr && hit(req_i.idx, IDX_LINE_SIZE);
	assign wr_base  = req_i.wr && hit(req_i.idx, IDX_IRQ_BASE);
	assign wr_known = wr_cnt || wr_line || wr_base;

	// base register word as software reads it, reserved bits zero
	function automatic logic [DATA_W-1:0] irq_word(input logic boot, input logic en,
		input logic [BASE_W-1:0] base);
		irq_word                     = '0;
		irq_word[BOOT_FLAG_BIT]      = boot; // RULE11
		irq_word[GEN_BIT]            = en; // RULE12
		irq_word[BASE_LSB +: BASE_W] = base; // RULE13
	endfunction : irq_word

	cycle_counter u_cnt (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.wr_i       (wr_cnt),
		.ext_mode_i (ext_wr_mode_i),
		.wdata_i    (req_i.wdata),
		.count_o    (cnt)
	); // RULE5

	// machine-check capture
	always_comb
	begin
		mc_addr_d = mc_addr_q;
		mc_type_d = mc_type_q;
		if (mc_log_i)
		begin
			mc_addr_d = mc_addr_i;
			mc_type_d = mc_type_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mc_addr_q <= '0;
			mc_type_q <= '0;
		end
		else
		begin
			mc_addr_q <= mc_addr_d;
			mc_type_q <= mc_type_d;
		end
	end

	// watch line and interrupt-controller state
	always_comb
	begin
		line_d      = line_q;
		gen_d       = gen_q;
		base_d      = base_q;
		boot_flag_d = boot_s2_q; // RULE11
		plat_d      = plat_s2_q; // RULE10
		if (wr_line)
			line_d = req_i.wdata[LINE_W-1:0]; // RULE1
		if (wr_base)
		begin
			gen_d  = req_i.wdata[GEN_BIT]; // RULE12
			base_d = req_i.wdata[BASE_LSB +: BASE_W]; // RULE13
		end
	end

	// read answer, one cycle after the request
	always_comb
	begin
		rsp_d       = '0;
		rsp_d.valid = req_i.rd || req_i.wr;
		if (req_i.rd)
		begin
			if (hit(req_i.idx, IDX_MC_ADDR))
				rsp_d.rdata = mc_addr_q;
			else if (hit(req_i.idx, IDX_MC_TYPE))
				rsp_d.rdata = mc_type_q;
			else if (hit(req_i.idx, IDX_LINE_SIZE))
				rsp_d.rdata[LINE_W-1:0] = line_q; // RULE1
			else if (hit(req_i.idx, IDX_CYCLE_CNT))
				rsp_d.rdata = cnt; // RULE6
			else if (hit(req_i.idx, IDX_PLATFORM))
				rsp_d.rdata[PLAT_LSB +: PLAT_W] = plat_q; // RULE10
			else if (hit(req_i.idx, IDX_IRQ_BASE))
				rsp_d.rdata = irq_word(boot_flag_q, gen_q, base_q); // RULE11 RULE12 RULE13
			else
				rsp_d.fault = 1'b1;
		end
		else if (req_i.wr)
		begin
			rsp_d.fault = !wr_known;
		end
	end

	// answer register
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rsp_q <= '0;
		else
			rsp_q <= rsp_d;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			line_q    <= LINE_SIZE_RST; // RULE2
			gen_q     <= 1'b0;
			base_q    <= IRQ_BASE_RST;
			boot_flag_q <= 1'b0;
			plat_q    <= '0;
		end
		else
		begin
			line_q    <= line_d;
			gen_q     <= gen_d;
			base_q    <= base_d;
			boot_flag_q <= boot_flag_d;
			plat_q    <= plat_d;
		end
	end

	// register outputs
	assign rsp_o                      = rsp_q;
	assign watch_line_size_o          = line_q; // RULE3
	assign cycle_count_o              = cnt;
	assign irq_ctrl_enable_o          = gen_q;
	assign irq_ctrl_base_o            = base_q;
	assign bootstrap_processor_flag_o = boot_flag_q;
endmodule : cfg_reg_bank

// file: core/cfg_reg_pkg.sv
// package: register indices, field layouts and reset values of the config register bank
// What this block does
// RULE1: watch line-size is a 16-bit read/write field
// RULE2: line-size resets to 0x40, sixty-four bytes
// RULE3: line-size sets monitored region spacing and alignment
// RULE4: firmware writes larger of line-size and chipset buffer
// RULE5: cycle counter is one 64-bit quadword register
// RULE6: counter reads return the present full count
// RULE7: legacy mode writes low half, clears high
// RULE8: extended mode writes all 64 counter bits
// RULE9: counter increments each cycle, wraps, resets zero
// RULE10: platform register exposes read-only 3-bit field
// RULE11: boot-processor flag set when chosen bootstrap
// RULE12: global enable flag mirrors controller enable state
// RULE13: 20-bit field holds controller window base address
package cfg_reg_pkg;
	localparam int          ADDR_W          = 32;
	localparam int          DATA_W          = 64;
	localparam int          LINE_W          = 16;
	localparam int          PLAT_W          = 3;
	localparam int          BASE_W          = 20;
	localparam int          HALF_W          = 32;

	localparam logic [31:0] IDX_MC_ADDR     = 32'h0000_0000;
	localparam logic [31:0] IDX_MC_TYPE     = 32'h0000_0001;
	localparam logic [31:0] IDX_LINE_SIZE   = 32'h0000_0006;
	localparam logic [31:0] IDX_CYCLE_CNT   = 32'h0000_0010;
	localparam logic [31:0] IDX_PLATFORM    = 32'h0000_0017;
	localparam logic [31:0] IDX_IRQ_BASE    = 32'h0000_001b;

	localparam logic [15:0] LINE_SIZE_RST   = 16'h0040;
	localparam int          PLAT_LSB        = 50;
	localparam int          BOOT_FLAG_BIT   = 8;
	localparam int          GEN_BIT         = 11;
	localparam int          BASE_LSB        = 12;
	localparam logic [19:0] IRQ_BASE_RST    = 20'h0_0000;

	// one access request from the instruction pipeline
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] idx;
		logic [DATA_W-1:0] wdata;
	} cfg_req_s;

	// answer to the request, one cycle later
	typedef struct packed {
		logic              valid;
		logic              fault;
		logic [DATA_W-1:0] rdata;
	} cfg_rsp_s;
endpackage : cfg_reg_pkg

// file: core/cycle_counter.sv
// module: free-running 64-bit cycle counter with legacy and extended write modes
module cycle_counter
	import cfg_reg_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	// write access
	input  wire logic              wr_i,
	input  wire logic              ext_mode_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	// count
	output logic      [DATA_W-1:0] count_o
);
	logic [DATA_W-1:0] count_q;
	logic [DATA_W-1:0] count_d;

	always_comb
	begin
		count_d = count_q + 64'h0000_0000_0000_0001; // RULE9
		if (wr_i)
		begin
			if (ext_mode_i)
				count_d = wdata_i; // RULE8
			else
				count_d = {{HALF_W{1'b0}}, wdata_i[HALF_W-1:0]}; // RULE7
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_q <= '0; // RULE9
		else
			count_q <= count_d;
	end

	assign count_o = count_q;
endmodule : cycle_counter

// file: tb/cfg_reg_monitor.sv
// checker: port properties of the config register bank
module cfg_reg_monitor
	import cfg_reg_pkg::*;
(
	// clock and reset
	input wire logic              clk_sys_i,
	input wire logic              rst_n_i,
	// access and outputs
	input wire cfg_req_s          req_i,
	input wire cfg_rsp_s          rsp_o,
	input wire logic              ext_wr_mode_i,
	input wire logic [LINE_W-1:0] watch_line_size_o,
	input wire logic [DATA_W-1:0] cycle_count_o,
	input wire logic              irq_ctrl_enable_o,
	input wire logic [BASE_W-1:0] irq_ctrl_base_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire acc     = req_i.rd | req_i.wr;
	wire wr_cnt  = req_i.wr && req_i.idx == IDX_CYCLE_CNT;
	wire wr_line = req_i.wr && req_i.idx == IDX_LINE_SIZE;
	wire rd_line = req_i.rd && req_i.idx == IDX_LINE_SIZE;
	wire wr_base = req_i.wr && req_i.idx == IDX_IRQ_BASE;
	a_rsp_latency: assert property (acc |=> rsp_o.valid)
		else $error("answer missing");
	a_rsp_quiet: assert property (!acc |=> !rsp_o.valid)
		else $error("answer without request");
	a_cnt_step: assert property (!wr_cnt |=> cycle_count_o == $past(cycle_count_o) + 64'h1)
		else $error("counter did not step");
	a_cnt_ext: assert property (wr_cnt && ext_wr_mode_i |=> cycle_count_o == $past(req_i.wdata))
		else $error("full write lost");
	a_cnt_legacy: assert property (wr_cnt && !ext_wr_mode_i
		|=> cycle_count_o == {32'h0000_0000, $past(req_i.wdata[31:0])})
		else $error("legacy write wrong");
	a_line_load: assert property (wr_line |=> watch_line_size_o == $past(req_i.wdata[15:0]))
		else $error("line size not loaded");
	a_line_hold: assert property (!wr_line |=> $stable(watch_line_size_o))
		else $error("line size changed");
	a_line_read: assert property (rd_line
		|=> rsp_o.rdata == {48'h0000_0000_0000, $past(watch_line_size_o)})
		else $error("line size read wrong");
	a_base_load: assert property (wr_base
		|=> irq_ctrl_base_o == $past(req_i.wdata[31:12]) && irq_ctrl_enable_o == $past(req_i.wdata[11]))
		else $error("base register not loaded");
	c_cnt_wr: cover property (wr_cnt);
	c_line_wr: cover property (wr_line);
	c_base_wr: cover property (wr_base);
endmodule : cfg_reg_monitor

bind cfg_reg_bank cfg_reg_monitor u_mon (.*);

// file: tb/test_cfg_reg_bank.sv
// testbench: directed scenarios for the config register bank
module test_cfg_reg_bank import cfg_reg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] CHIP_LINE = 16'h0080;
	logic              clk_sys_i, rst_n_i, ext_wr_mode_i, boot_sel_i, flt;
	logic [PLAT_W-1:0] platform_id_i;
	cfg_req_s          req_i;
	cfg_rsp_s          rsp_o;
	logic [LINE_W-1:0] watch_line_size_o;
	logic [DATA_W-1:0] cycle_count_o, rdat;
	logic              irq_ctrl_enable_o, bootstrap_processor_flag_o;
	logic [BASE_W-1:0] irq_ctrl_base_o;
	int                err_total, n_checks;
	logic              mc_log_i;
	logic [DATA_W-1:0] mc_addr_i, mc_type_i;
	cfg_reg_bank u_dut (
		.clk_sys_i                  (clk_sys_i),
		.rst_n_i                    (rst_n_i),
		.req_i                      (req_i),
		.rsp_o                      (rsp_o),
		.ext_wr_mode_i              (ext_wr_mode_i),
		.mc_log_i                   (mc_log_i),
		.mc_addr_i                  (mc_addr_i),
		.mc_type_i                  (mc_type_i),
		.platform_id_i              (platform_id_i),
		.boot_sel_i                 (boot_sel_i),
		.watch_line_size_o          (watch_line_size_o),
		.cycle_count_o              (cycle_count_o),
		.irq_ctrl_enable_o          (irq_ctrl_enable_o),
		.irq_ctrl_base_o            (irq_ctrl_base_o),
		.bootstrap_processor_flag_o (bootstrap_processor_flag_o)
	);
	initial
	begin
		clk_sys_i = 0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [31:0] idx, input logic [63:0] wd);
		@(negedge clk_sys_i);
		req_i = '{rd: !w, wr: w, idx: idx, wdata: wd};
		@(negedge clk_sys_i);
		req_i.rd = 0;
		req_i.wr = 0;
		chk(rsp_o.valid, 1);
		rdat = rsp_o.rdata;
		flt = rsp_o.fault;
	endtask : acc
	task t_line;
		logic [15:0] m;
		chk(watch_line_size_o, 16'h0040);
		acc(0, IDX_LINE_SIZE, 0);
		chk(rdat, 64'h0000_0000_0000_0040);
		m = (CHIP_LINE > rdat[15:0]) ? CHIP_LINE : rdat[15:0];
		acc(1, IDX_LINE_SIZE, {48'hffff_ffff_ffff, m});
		chk(watch_line_size_o, m);
		acc(0, IDX_LINE_SIZE, 0);
		chk(rdat, {48'h0000_0000_0000, m});
		$display("t_line done");
	endtask : t_line
	task t_cnt;
		acc(1, IDX_CYCLE_CNT, 64'h1234_5678_9abc_def0);
		chk(cycle_count_o, 64'h1234_5678_9abc_def0);
		acc(0, IDX_CYCLE_CNT, 0);
		chk(rdat, 64'h1234_5678_9abc_def1);
		ext_wr_mode_i = 0;
		acc(1, IDX_CYCLE_CNT, 64'hffff_ffff_ffff_fffe);
		chk(cycle_count_o, 64'h0000_0000_ffff_fffe);
		ext_wr_mode_i = 1;
		acc(1, IDX_CYCLE_CNT, 64'hffff_ffff_ffff_ffff);
		@(negedge clk_sys_i);
		chk(cycle_count_o, 0);
		$display("t_cnt done");
	endtask : t_cnt
	task t_rst;
		@(negedge clk_sys_i);
		rst_n_i = 0;
		@(negedge clk_sys_i);
		chk(watch_line_size_o, 16'h0040);
		chk(cycle_count_o, 0);
		rst_n_i = 1;
		@(negedge clk_sys_i);
		chk(cycle_count_o, 1);
		acc(0, IDX_LINE_SIZE, 0);
		chk(rdat, 64'h0000_0000_0000_0040);
		$display("t_rst done");
	endtask : t_rst
	task t_mc;
		@(negedge clk_sys_i);
		{mc_log_i, mc_addr_i, mc_type_i} = {1'b1, 64'h0123_4567_89ab_cdef, 64'h0000_0000_0000_0011};
		@(negedge clk_sys_i);
		{mc_log_i, mc_addr_i, mc_type_i} = '0;
		acc(0, IDX_MC_ADDR, 0);
		chk(rdat, 64'h0123_4567_89ab_cdef);
		acc(0, IDX_MC_TYPE, 0);
		chk(rdat, 64'h0000_0000_0000_0011);
		acc(1, IDX_MC_ADDR, 0);
		chk(flt, 1);
		acc(0, IDX_MC_ADDR, 0);
		chk(rdat, 64'h0123_4567_89ab_cdef);
		$display("t_mc done");
	endtask : t_mc
	task t_ro;
		platform_id_i = 3'h5;
		repeat (4) @(negedge clk_sys_i);
		acc(1, IDX_PLATFORM, '1);
		chk(flt, 1);
		acc(0, IDX_PLATFORM, 0);
		chk(rdat, 64'h0014_0000_0000_0000);
		acc(0, 32'h0000_0002, 0);
		chk(flt, 1);
		chk(rdat, 0);
		$display("t_ro done");
	endtask : t_ro
	task t_irq;
		boot_sel_i = 1;
		acc(1, IDX_IRQ_BASE, 64'hffff_ffff_fedc_b800);
		repeat (2) @(negedge clk_sys_i);
		chk({irq_ctrl_base_o, irq_ctrl_enable_o, bootstrap_processor_flag_o}, 22'h3f_b72f);
		acc(0, IDX_IRQ_BASE, 0);
		chk(rdat, 64'h0000_0000_fedc_b900);
		boot_sel_i = 0;
		acc(1, IDX_IRQ_BASE, 64'h0000_0000_0000_1000);
		repeat (2) @(negedge clk_sys_i);
		acc(0, IDX_IRQ_BASE, 0);
		chk(rdat, 64'h0000_0000_0000_1000);
		chk(irq_ctrl_enable_o, 0);
		$display("t_irq done");
	endtask : t_irq
	task conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	initial
	begin
		#200000;
		err_total++;
		conclude;
	end
	initial
	begin
		{req_i, ext_wr_mode_i, boot_sel_i, platform_id_i, rst_n_i} = '0;
		{mc_log_i, mc_addr_i, mc_type_i} = '0;
		ext_wr_mode_i = 1;
		repeat (20) @(negedge clk_sys_i);
		rst_n_i = 1;
		t_line;
		t_rst;
		t_cnt;
		t_ro;
		t_mc;
		t_irq;
		conclude;
	end
endmodule : test_cfg_reg_bank
